//--- rtl/lsf_pkg.sv
// Behaviour
// - state logic runs on the local clock; ring clock times the hold interval and gates relay release
// - hold interval ends after 128 periods of the ring frequency clock
// - power-on or chip reset pin low forces power-down
// - active mode enters high-impedance feeding unless already active, leaves to stand-by on hiz off-hook
// - hiz off-hook used only in hiz feeding; line off-hook in stand-by/active/on-hook transmission
// - stand-by goes to active at once on line off-hook
// - stand-by without off-hook holds one interval, flags timeout, returns to hiz
// - active drives detect low while line off-hook stays high
// - on-hook in active: detect high at once, hold interval, timeout, back to hiz (on-hook transmission under that mode word)
// - off-hook again during active hold interval resumes conversation, detect low
// - mode 0,0,1 is ringing; ring trip goes active with pre-ringing polarity
// - ring trip shows on detect; controller then swaps ringing word for active
// - mode_sel_a low, mode_sel_b high is on-hook transmission; off-hook goes active
// - ring trip releases relay only while ring clock low, detect low, active
// - ring trip indications stay latched until the mode word changes or the chip reset pin goes low
package lsf_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADR_STATUS   = 4'h0;
	localparam logic [3:0] ADR_IRQ_STAT = 4'h4;
	localparam logic [3:0] ADR_IRQ_CLR  = 4'h8;
	localparam logic [3:0] ADR_IRQ_EN   = 4'hc;

	localparam int unsigned N_EVT        = 4;
	localparam int unsigned EVT_ACTIVE   = 0;
	localparam int unsigned EVT_TIMEOUT  = 1;
	localparam int unsigned EVT_RINGTRIP = 2;
	localparam int unsigned EVT_ONHOOK   = 3;
	localparam logic [3:0]  IRQ_EN_RST   = 4'h0;

	// status field positions
	localparam int unsigned ST_STATE_LSB = 0;
	localparam int unsigned ST_DET       = 3;
	localparam int unsigned ST_RELAY     = 4;
	localparam int unsigned ST_TIMEOUT   = 5;
	localparam int unsigned ST_POLARITY  = 6;
	localparam int unsigned ST_MODE_LSB  = 7;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam logic [7:0] HOLD_PERIODS = 8'h80;
	localparam logic [7:0] HOLD_LAST    = HOLD_PERIODS - 8'h01;
	localparam int unsigned N_SYNC      = 8;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LSF_PDOWN, LSF_HIZ, LSF_STBY, LSF_ACTIVE, LSF_RING, LSF_OHTX
	} lsf_state_t;

	typedef enum logic [1:0] {
		MODE_PDOWN, MODE_ACTIVE, MODE_RING, MODE_OHTX
	} lsf_mode_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} lsf_wb_req_t;

	typedef struct packed {
		logic chip_reset_n;
		logic ring_trip_flag;
		logic line_offhook_flag;
		logic hiz_offhook_flag;
		logic ring_freq_clock;
		logic mode_sel_polarity;
		logic mode_sel_b;
		logic mode_sel_a;
	} lsf_pins_t;

endpackage : lsf_pkg

//--- rtl/lsf_line_fsm.sv
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ps
module lsf_line_fsm
	import lsf_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	// wishbone slave
	input  wire lsf_wb_req_t wb_req,
	output logic             wb_ack_o,
	output logic [31:0]      wb_dat_o,
	// line card pins
	input  wire lsf_pins_t   pins,
	output logic             det_n,
	output logic             ring_relay_drive,
	output logic             timeout_flag,
	output logic             line_polarity,
	output lsf_state_t       line_state,
	// interrupt
	output logic             irq
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [N_SYNC-1:0] pin_raw;
	logic [N_SYNC-1:0] pin_f;
	assign pin_raw = pins;

	genvar gi;
	generate
		for (gi = 0; gi < N_SYNC; gi++)
		begin : g_sync
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic f_r;
			// three stages, accept when last two agree
			always_ff @(posedge ref_clk or negedge nrst)
			begin
				if (!nrst)
				begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
					s3_r <= 1'b0;
					f_r  <= 1'b0;
				end
				else
				begin
					s1_r <= pin_raw[gi];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r)
						f_r <= s3_r;
				end
			end
			assign pin_f[gi] = f_r;
		end
	endgenerate

	lsf_pins_t pf;
	assign pf = pin_f;

	// ----------------------------------------------------------------
	// mode decode and ring clock edge
	// ----------------------------------------------------------------
	lsf_mode_t mode_w;
	lsf_mode_t mode_prev_r;
	logic      ring_clk_prev_r;
	wire       ring_edge  = pf.ring_freq_clock & ~ring_clk_prev_r;
	wire       mode_chg   = (mode_w != mode_prev_r);
	wire       chip_rst_w = ~pf.chip_reset_n;

	// mode_sel_a high means active, b and polarity ignored
	// 0,0,1 rings; 0,1,x is on-hook transmission
	assign mode_w = pf.mode_sel_a ? MODE_ACTIVE :
			pf.mode_sel_b ? MODE_OHTX :
			pf.mode_sel_polarity ? MODE_RING : MODE_PDOWN;

	// ----------------------------------------------------------------
	// supervision state machine
	// ----------------------------------------------------------------
	lsf_state_t state_r;
	lsf_state_t state_nxt;
	logic [7:0] hold_cnt_r;
	logic [7:0] hold_cnt_nxt;
	logic       hold_r;
	logic       hold_nxt;
	logic       tmo_r;
	logic       tmo_nxt;
	logic       trip_r;
	logic       trip_nxt;
	logic       relay_nxt;
	logic       det_nxt;

	// expiry on the 128th ring clock period since restart
	wire        hold_expire = ring_edge & (hold_cnt_r == HOLD_LAST);
	wire        cnt_run     = (state_r == LSF_STBY) | ((state_r == LSF_ACTIVE) & hold_r);
	// hold ending from on-hook transmission falls back to that mode, not hiz
	wire lsf_state_t tmo_home = (mode_w == MODE_OHTX) ? LSF_OHTX : LSF_HIZ;

	always_comb
	begin
		state_nxt    = state_r;
		hold_nxt     = hold_r;
		tmo_nxt      = 1'b0;
		trip_nxt     = trip_r;
		hold_cnt_nxt = (cnt_run && ring_edge) ? hold_cnt_r + 8'h01 : hold_cnt_r;
		if (chip_rst_w)
		begin
			state_nxt = LSF_PDOWN;
			hold_nxt  = 1'b0;
			trip_nxt  = 1'b0;
		end
		else if (mode_chg)
		begin
			// any new mode word drops the ring trip latch
			trip_nxt = 1'b0;
			hold_nxt = 1'b0;
			unique case (mode_w)
				// active word starts hiz feeding unless already in a call
				MODE_ACTIVE: state_nxt = (state_r == LSF_ACTIVE) ? LSF_ACTIVE : LSF_HIZ;
				MODE_RING:   state_nxt = LSF_RING;
				MODE_OHTX:   state_nxt = (state_r == LSF_ACTIVE) ? LSF_ACTIVE : LSF_OHTX;
				MODE_PDOWN:  state_nxt = LSF_PDOWN;
			endcase
		end
		else if (tmo_r)
		begin
			// timeout returns to feeding, flag clears on the move
			state_nxt = tmo_home;
			hold_nxt  = 1'b0;
		end
		else
		begin
			unique case (state_r)
				LSF_PDOWN: ;
				LSF_HIZ:
					// only the hiz flag is looked at here
					if (pf.hiz_offhook_flag)
					begin
						state_nxt    = LSF_STBY;
						hold_cnt_nxt = 8'h00;
					end
				LSF_STBY:
					// off-hook confirmed goes active at once
					if (pf.line_offhook_flag)
						state_nxt = LSF_ACTIVE;
					else if (hold_expire)
						tmo_nxt = 1'b1;
				LSF_ACTIVE:
					if (trip_r)
						;
					else if (hold_r)
					begin
						if (pf.line_offhook_flag)
							hold_nxt = 1'b0;
						else if (hold_expire)
							tmo_nxt = 1'b1;
					end
					else if (!pf.line_offhook_flag)
					begin
						hold_nxt     = 1'b1;
						hold_cnt_nxt = 8'h00;
					end
				LSF_RING:
					if (pf.ring_trip_flag)
					begin
						state_nxt = LSF_ACTIVE;
						trip_nxt  = 1'b1;
					end
				LSF_OHTX:
					if (pf.line_offhook_flag)
						state_nxt = LSF_ACTIVE;
				default:
					state_nxt = LSF_PDOWN;
			endcase
		end
		// detect low in conversation or after ring trip
		det_nxt   = ~(((state_nxt == LSF_ACTIVE) & ~hold_nxt) | trip_nxt);
		// relay let go only while the ring clock is low, or at once on chip reset
		// a mode change that clears the trip latch must still wait for a low ring clock
		relay_nxt = (state_nxt == LSF_RING) |
			(ring_relay_drive & pf.ring_freq_clock & ~chip_rst_w);
	end

	// one local clock; ring clock is only sampled
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r          <= LSF_PDOWN;
			mode_prev_r      <= MODE_PDOWN;
			ring_clk_prev_r  <= 1'b0;
			hold_cnt_r       <= 8'h00;
			hold_r           <= 1'b0;
			tmo_r            <= 1'b0;
			trip_r           <= 1'b0;
			det_n            <= 1'b1;
			ring_relay_drive <= 1'b0;
			line_polarity    <= 1'b0;
		end
		else
		begin
			state_r          <= state_nxt;
			// held at power-down while reset so the mode word is re-applied after
			mode_prev_r      <= chip_rst_w ? MODE_PDOWN : mode_w;
			ring_clk_prev_r  <= pf.ring_freq_clock;
			hold_cnt_r       <= hold_cnt_nxt;
			hold_r           <= hold_nxt;
			tmo_r            <= tmo_nxt;
			trip_r           <= trip_nxt;
			det_n            <= det_nxt;
			ring_relay_drive <= relay_nxt;
			if (mode_w != MODE_RING)
				line_polarity <= pf.mode_sel_polarity;
		end
	end

	assign line_state   = state_r;
	assign timeout_flag = tmo_r;

	// ----------------------------------------------------------------
	// events and interrupt
	// ----------------------------------------------------------------
	logic [N_EVT-1:0] evt;
	logic [N_EVT-1:0] irq_stat_r;
	logic [N_EVT-1:0] irq_en_r;
	logic [N_EVT-1:0] irq_clr;
	logic [N_EVT-1:0] irq_stat_nxt;

	assign evt[EVT_ACTIVE]   = (state_nxt == LSF_ACTIVE) & (state_r != LSF_ACTIVE);
	assign evt[EVT_TIMEOUT]  = tmo_nxt;
	assign evt[EVT_RINGTRIP] = trip_nxt & ~trip_r;
	assign evt[EVT_ONHOOK]   = hold_nxt & ~hold_r;

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	// ack one cycle after the request; writes land on the ack edge
	wire        wb_hit   = wb_req.cyc & wb_req.stb;
	wire        wb_wr    = wb_hit & wb_req.we & wb_ack_o & wb_req.sel[0];
	wire        wr_clr   = wb_wr & (wb_req.adr == ADR_IRQ_CLR);
	wire        wr_en    = wb_wr & (wb_req.adr == ADR_IRQ_EN);
	logic [31:0] rd_mux;

	assign irq_clr      = wr_clr ? wb_req.dat[N_EVT-1:0] : '0;
	// new events win over a clear in the same cycle
	assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | evt;

	assign rd_mux =
		(wb_req.adr == ADR_STATUS) ?
			{23'h0, mode_w, line_polarity, tmo_r, ring_relay_drive, det_n, state_r} :
		(wb_req.adr == ADR_IRQ_STAT) ? {28'h0, irq_stat_r} :
		(wb_req.adr == ADR_IRQ_EN)   ? {28'h0, irq_en_r} : 32'h0;

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wb_ack_o   <= 1'b0;
			wb_dat_o   <= 32'h0;
			irq_stat_r <= '0;
			irq_en_r   <= IRQ_EN_RST;
			irq        <= 1'b0;
		end
		else
		begin
			wb_ack_o   <= wb_hit & ~wb_ack_o;
			wb_dat_o   <= (wb_hit & ~wb_ack_o & ~wb_req.we) ? rd_mux : 32'h0;
			irq_stat_r <= irq_stat_nxt;
			if (wr_en)
				irq_en_r <= wb_req.dat[N_EVT-1:0];
			irq        <= |(irq_stat_nxt & (wr_en ? wb_req.dat[N_EVT-1:0] : irq_en_r));
		end
	end

endmodule : lsf_line_fsm

//--- test/lsf_monitor.sv
`timescale 1ns/1ps
module lsf_chk
	import lsf_pkg::*;
(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        nrst,
	// bus
	input wire lsf_wb_req_t wb_req,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// line
	input wire lsf_pins_t   pins,
	input wire logic        det_n,
	input wire logic        ring_relay_drive,
	input wire logic        timeout_flag,
	input wire logic        line_polarity,
	input wire lsf_state_t  line_state,
	input wire logic        irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_ack_resp; wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
	property p_to_pulse; timeout_flag |=> !timeout_flag; endproperty
	a_to_pulse: assert property (p_to_pulse) else $error("timeout too long");
	property p_to_src; timeout_flag |-> line_state inside {LSF_STBY, LSF_ACTIVE}; endproperty
	a_to_src: assert property (p_to_src) else $error("timeout in wrong state");
	property p_to_hiz;
		timeout_flag |=> line_state inside {LSF_HIZ, LSF_OHTX, LSF_PDOWN};
	endproperty
	a_to_hiz: assert property (p_to_hiz) else $error("no return after timeout");
	property p_act_det; $rose(line_state == LSF_ACTIVE) |-> !det_n; endproperty
	a_act_det: assert property (p_act_det) else $error("active without detect");
	property p_pdown; !pins.chip_reset_n [*6] |-> line_state == LSF_PDOWN; endproperty
	a_pdown: assert property (p_pdown) else $error("reset pin ignored");
	property p_stby_in; $rose(line_state == LSF_STBY) |-> $past(line_state) == LSF_HIZ;
	endproperty
	a_stby_in: assert property (p_stby_in) else $error("stand-by not from hiz");
	property p_stby_out;
		line_state == LSF_STBY ##1 line_state == LSF_HIZ |-> $past(timeout_flag);
	endproperty
	a_stby_out: assert property (p_stby_out) else $error("stand-by left early");
	c_trip: cover property ($fell(ring_relay_drive));
	c_to: cover property (timeout_flag);
	c_resume: cover property (line_state == LSF_ACTIVE && $fell(det_n));
endmodule : lsf_chk
bind lsf_line_fsm lsf_chk u_chk (.ref_clk, .nrst, .wb_req, .wb_ack_o, .wb_dat_o, .pins,
	.det_n, .ring_relay_drive, .timeout_flag, .line_polarity, .line_state, .irq);

//--- test/lsf_ctrl_model.sv
`timescale 1ns/1ps
module lsf_ctrl
	import lsf_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	// bench command
	input  wire logic       cmd_stb,
	input  wire logic [2:0] cmd,
	// device side, mode is {a, b, polarity}
	input  wire logic       det_n,
	output logic [2:0]      mode
);
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			mode <= 3'h0;
		else if (cmd_stb)
			mode <= cmd;
		else if (mode == 3'h1 && !det_n)
			mode <= 3'h4;
	end
endmodule : lsf_ctrl

//--- test/tb.sv
`timescale 1ns/1ps
module tb
	import lsf_pkg::*;
;
	logic        ref_clk, nrst, ack, det_n, relay, to, pol, irq;
	logic        crn, trip, loh, hoh, rck, cmd_stb;
	logic [2:0]  cmd, mode;
	logic [31:0] dat, rd;
	lsf_wb_req_t req;
	lsf_pins_t   pins;
	lsf_state_t  st;
	int          num_errors, total_checks, cyc_n, to_n;
	assign pins = {crn, trip, loh, hoh, rck, mode[0], mode[1], mode[2]};
	lsf_line_fsm DUT (.ref_clk, .nrst, .wb_req(req), .wb_ack_o(ack), .wb_dat_o(dat), .pins,
		.det_n, .ring_relay_drive(relay), .timeout_flag(to), .line_polarity(pol),
		.line_state(st), .irq);
	lsf_ctrl u_ctrl (.ref_clk, .nrst, .cmd_stb, .cmd, .det_n, .mode);
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic print_verdict();
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	// hang guard, runs need about 2700 cycles
	always @(posedge ref_clk)
	begin
		cyc_n <= cyc_n + 1;
		if (to)
			to_n <= to_n + 1;
		if (cyc_n == 20000)
		begin
			num_errors++;
			print_verdict();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cy(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cy
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		req <= '{1'b1, 1'b1, we, a, 4'hf, d};
		cy(1);
		// no local limit: the hang guard ends a wait that never sees ack
		while (ack !== 1'b1)
			cy(1);
		rd = dat;
		req <= '0;
		cy(1);
	endtask : wb
	task automatic wst(input lsf_state_t s);
		int n = 0;
		while (st !== s && n < 60)
		begin
			cy(1);
			n++;
		end
		chk("state", st, s);
	endtask : wst
	task automatic ring(input int n);
		repeat (n)
		begin
			rck <= 1'b1;
			cy(4);
			rck <= 1'b0;
			cy(4);
		end
	endtask : ring
	task automatic md(input logic [2:0] m);
		cmd <= m;
		cmd_stb <= 1'b1;
		cy(1);
		cmd_stb <= 1'b0;
	endtask : md
	initial
	begin
		{nrst, crn, trip, loh, hoh, rck, cmd_stb, cmd} = '0;
		req = '0;
		{num_errors, total_checks, cyc_n, to_n} = '0;
		cy(5);
		nrst <= 1'b1;
		crn <= 1'b1;
		cy(8);
		wst(LSF_PDOWN);
		wb(0, ADR_IRQ_EN, 0);
		chk("irq_en", rd, 0);
		wb(0, 4'h2, 0);
		chk("unmapped", rd, 0);
		wb(1, ADR_IRQ_EN, 32'hf);
		wb(0, ADR_IRQ_EN, 0);
		chk("irq_en", rd, 32'hf);
		md(3'h4);
		wst(LSF_HIZ);
		loh <= 1'b1;
		cy(12);
		chk("state", st, LSF_HIZ);
		hoh <= 1'b1;
		wst(LSF_ACTIVE);
		chk("det_n", det_n, 0);
		{hoh, loh} <= 2'b00;
		cy(8);
		chk("det_n", det_n, 1);
		ring(60);
		loh <= 1'b1;
		cy(8);
		chk("det_n", det_n, 0);
		loh <= 1'b0;
		cy(8);
		ring(127);
		cy(8);
		chk("state", st, LSF_ACTIVE);
		ring(1);
		wst(LSF_HIZ);
		chk("timeouts", to_n, 1);
		chk("irq", irq, 1);
		wb(0, ADR_IRQ_STAT, 0);
		chk("irq_stat", rd & 32'ha, 32'ha);
		wb(1, ADR_IRQ_CLR, 32'hf);
		wb(1, ADR_IRQ_EN, 0);
		cy(2);
		chk("irq", irq, 0);
		hoh <= 1'b1;
		wst(LSF_STBY);
		hoh <= 1'b0;
		ring(127);
		cy(8);
		chk("state", st, LSF_STBY);
		ring(1);
		wst(LSF_HIZ);
		chk("timeouts", to_n, 2);
		chk("irq", irq, 0);
		md(3'h1);
		wst(LSF_RING);
		chk("relay", relay, 1);
		chk("polarity", pol, 0);
		{rck, trip} <= 2'b11;
		wst(LSF_ACTIVE);
		chk("relay", relay, 1);
		{rck, trip} <= 2'b00;
		cy(10);
		chk("relay", relay, 0);
		chk("state", st, LSF_ACTIVE);
		md(3'h0);
		wst(LSF_PDOWN);
		md(3'h2);
		wst(LSF_OHTX);
		loh <= 1'b1;
		wst(LSF_ACTIVE);
		crn <= 1'b0;
		cy(8);
		chk("state", st, LSF_PDOWN);
		print_verdict();
	end
endmodule : tb
